// file: inc/flop_prims_pkg.sv
// constants for the sampled single-bit storage primitives
// assumes one system clock; all user-side lines arrive asynchronously
package flop_prims_pkg;

  // when an asserted set or clear line acts on the output
  typedef enum logic [0:0] {
    STYLE_UNCLOCKED = 1'b0,
    STYLE_CLOCKED = 1'b1
  } set_clear_timing_style_type;

  // power-up values of each variant
  localparam logic CLEAR_FLOP_INIT = 1'b0;
  localparam logic SET_FLOP_INIT = 1'b1;
  localparam logic PRESET_FLOP_INIT = 1'b1;

  // value forced by each control line
  localparam logic CLEAR_FORCE_VAL = 1'b0;
  localparam logic SET_FORCE_VAL = 1'b1;

  // synchroniser depth and input vector layout
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_WIDTH = 9;
  localparam int IDX_PRESET_LOW = 0;
  localparam int IDX_PRESET_EN = 1;
  localparam int IDX_PRESET_DATA = 2;
  localparam int IDX_FORCE_HIGH_LOW = 3;
  localparam int IDX_SET_DATA = 4;
  localparam int IDX_CLEAR_LOW = 5;
  localparam int IDX_CLEAR_DATA = 6;
  localparam int IDX_NEG_TIMING = 7;
  localparam int IDX_POS_TIMING = 8;

  // idle levels: active-low lines rest high, the rest low
  localparam logic [8:0] SYNC_RESET_VAL = 9'h029;

endpackage

// file: hw/sampled_flop_cell.sv
// one single-bit storage cell with a forcing line, enable and data
// assumes edge and control inputs are already synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none

module sampled_flop_cell #(
  parameter logic INIT = 1'b0,
  parameter logic FORCE_VAL = 1'b0,
  parameter flop_prims_pkg::set_clear_timing_style_type STYLE =
    flop_prims_pkg::STYLE_UNCLOCKED
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic edge_in,
  input wire logic force_low_in,
  input wire logic enable_in,
  input wire logic data_in,
  output logic q
);

  logic q_q;
  logic q_d;

  // enable gates everything; forcing wins over data
  always_comb begin
    q_d = q_q;
    if (enable_in) begin
      if (!force_low_in &&
          (STYLE == flop_prims_pkg::STYLE_UNCLOCKED || edge_in)) begin
        q_d = FORCE_VAL;
      end else if (edge_in) begin
        q_d = data_in;
      end
    end
  end

  // power-up value is the reset constant of a generic flop
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_q <= INIT;
    end else begin
      q_q <= q_d;
    end
  end

  assign q = q_q;

endmodule

`default_nettype wire

// file: hw/flop_prims_top.sv
// sampled models of three single-bit storage primitives
// assumes user lines are asynchronous to sys_clk and are synchronised here
`timescale 1ns/1ps
`default_nettype none

module flop_prims_top #(
  parameter logic CLEAR_INIT = flop_prims_pkg::CLEAR_FLOP_INIT,
  parameter logic SET_INIT = flop_prims_pkg::SET_FLOP_INIT,
  parameter logic PRESET_INIT = flop_prims_pkg::PRESET_FLOP_INIT,
  parameter flop_prims_pkg::set_clear_timing_style_type CLEAR_STYLE =
    flop_prims_pkg::STYLE_UNCLOCKED,
  parameter flop_prims_pkg::set_clear_timing_style_type SET_STYLE =
    flop_prims_pkg::STYLE_UNCLOCKED
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pos_edge_timing_in,
  input wire logic neg_edge_timing_in,
  input wire logic clear_data_in,
  input wire logic clear_low_in,
  input wire logic set_data_in,
  input wire logic force_high_low_in,
  input wire logic preset_data_in,
  input wire logic preset_enable_in,
  input wire logic sync_preset_low_in,
  output logic async_clear_flop_q,
  output logic async_set_flop_q,
  output logic neg_edge_sync_preset_flop_q
);

  localparam int W = flop_prims_pkg::SYNC_WIDTH;

  logic [W-1:0] raw_in;
  logic [W-1:0] sync_q [flop_prims_pkg::SYNC_STAGES];
  logic [W-1:0] sync_d [flop_prims_pkg::SYNC_STAGES];
  logic pos_prev_q;
  logic pos_prev_d;
  logic neg_prev_q;
  logic neg_prev_d;
  logic [W-1:0] s;
  logic rise;
  logic fall;

  // gather the asynchronous user lines into one vector
  assign raw_in = {pos_edge_timing_in, neg_edge_timing_in, clear_data_in,
                   clear_low_in, set_data_in, force_high_low_in,
                   preset_data_in, preset_enable_in, sync_preset_low_in};

  // two-stage synchroniser; only the last stage feeds logic
  genvar g;
  generate
    for (g = 0; g < flop_prims_pkg::SYNC_STAGES; g++) begin : g_sync
      if (g == 0) begin : g_first
        always_comb begin
          sync_d[g] = raw_in;
        end
      end else begin : g_next
        always_comb begin
          sync_d[g] = sync_q[g-1];
        end
      end
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync_q[g] <= flop_prims_pkg::SYNC_RESET_VAL;
        end else begin
          sync_q[g] <= sync_d[g];
        end
      end
    end
  endgenerate

  assign s = sync_q[flop_prims_pkg::SYNC_STAGES-1];

  // previous timing levels for edge detection
  always_comb begin
    pos_prev_d = s[flop_prims_pkg::IDX_POS_TIMING];
    neg_prev_d = s[flop_prims_pkg::IDX_NEG_TIMING];
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_prev_q <= 1'b0;
      neg_prev_q <= 1'b0;
    end else begin
      pos_prev_q <= pos_prev_d;
      neg_prev_q <= neg_prev_d;
    end
  end

  // one-cycle strobes for the timing input edges
  assign rise = s[flop_prims_pkg::IDX_POS_TIMING] & ~pos_prev_q;
  assign fall = ~s[flop_prims_pkg::IDX_NEG_TIMING] & neg_prev_q;

  // rising-edge flop with active-low clear; also serves the clear alias
  sampled_flop_cell #(
    .INIT(CLEAR_INIT),
    .FORCE_VAL(flop_prims_pkg::CLEAR_FORCE_VAL),
    .STYLE(CLEAR_STYLE)
  ) u_clear_flop (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .edge_in(rise),
    .force_low_in(s[flop_prims_pkg::IDX_CLEAR_LOW]),
    .enable_in(1'b1),
    .data_in(s[flop_prims_pkg::IDX_CLEAR_DATA]),
    .q(async_clear_flop_q)
  );

  // rising-edge flop with active-low set; also serves the preset alias
  sampled_flop_cell #(
    .INIT(SET_INIT),
    .FORCE_VAL(flop_prims_pkg::SET_FORCE_VAL),
    .STYLE(SET_STYLE)
  ) u_set_flop (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .edge_in(rise),
    .force_low_in(s[flop_prims_pkg::IDX_FORCE_HIGH_LOW]),
    .enable_in(1'b1),
    .data_in(s[flop_prims_pkg::IDX_SET_DATA]),
    .q(async_set_flop_q)
  );

  // falling-edge flop with enable and synchronous preset
  sampled_flop_cell #(
    .INIT(PRESET_INIT),
    .FORCE_VAL(flop_prims_pkg::SET_FORCE_VAL),
    .STYLE(flop_prims_pkg::STYLE_CLOCKED)
  ) u_preset_flop (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .edge_in(fall),
    .force_low_in(s[flop_prims_pkg::IDX_PRESET_LOW]),
    .enable_in(s[flop_prims_pkg::IDX_PRESET_EN]),
    .data_in(s[flop_prims_pkg::IDX_PRESET_DATA]),
    .q(neg_edge_sync_preset_flop_q)
  );

  // checks on the sampled behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic clr_l;
  logic set_l;
  logic pre_l;
  logic pre_en;
  assign clr_l = s[flop_prims_pkg::IDX_CLEAR_LOW];
  assign set_l = s[flop_prims_pkg::IDX_FORCE_HIGH_LOW];
  assign pre_l = s[flop_prims_pkg::IDX_PRESET_LOW];
  assign pre_en = s[flop_prims_pkg::IDX_PRESET_EN];

  a_clear_forces_low: assert property (
    (CLEAR_STYLE == flop_prims_pkg::STYLE_UNCLOCKED && !clr_l)
      |=> !async_clear_flop_q)
    else $error("clear line did not force output low");

  a_clear_captures_data: assert property (
    (clr_l && rise)
      |=> async_clear_flop_q == $past(s[flop_prims_pkg::IDX_CLEAR_DATA]))
    else $error("clear flop missed data on rising edge");

  a_clear_holds_idle: assert property (
    (clr_l && !rise) |=> $stable(async_clear_flop_q))
    else $error("clear flop changed without an edge");

  a_clocked_clear_waits: assert property (
    (CLEAR_STYLE == flop_prims_pkg::STYLE_CLOCKED && !rise)
      |=> $stable(async_clear_flop_q))
    else $error("clocked clear acted without an edge");

  a_set_forces_high: assert property (
    (SET_STYLE == flop_prims_pkg::STYLE_UNCLOCKED && !set_l)
      ##1 !set_l |-> async_set_flop_q)
    else $error("set line did not force output high");

  a_set_captures_data: assert property (
    (set_l && rise)
      |=> async_set_flop_q == $past(s[flop_prims_pkg::IDX_SET_DATA]))
    else $error("set flop missed data on rising edge");

  a_set_clocked_edge: assert property (
    (SET_STYLE == flop_prims_pkg::STYLE_CLOCKED && !set_l && rise)
      |=> async_set_flop_q)
    else $error("clocked set did not act on the edge");

  a_preset_sets_high: assert property (
    (pre_en && !pre_l && fall) |=> neg_edge_sync_preset_flop_q)
    else $error("preset did not set output on falling edge");

  a_preset_loads_data: assert property (
    (pre_en && pre_l && fall)
      |=> neg_edge_sync_preset_flop_q ==
          $past(s[flop_prims_pkg::IDX_PRESET_DATA]))
    else $error("preset flop missed data on falling edge");

  a_preset_enable_hold: assert property (
    (!pre_en || !fall) |=> $stable(neg_edge_sync_preset_flop_q))
    else $error("preset flop changed while disabled or idle");

  c_clear_capture_one: cover property (
    clr_l && rise && s[flop_prims_pkg::IDX_CLEAR_DATA]);
  c_set_forced: cover property (!set_l ##1 async_set_flop_q);
  c_preset_on_fall: cover property (pre_en && !pre_l && fall);
  c_preset_disabled_fall: cover property (!pre_en && fall);

endmodule

`default_nettype wire

// file: tb/user_fabric_model.sv
// user fabric model: drives the data, timing and control lines of the flops
// assumes commands arrive as a vector in the package input layout
`timescale 1ns/1ps
`default_nettype none

module user_fabric_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [8:0] cmd,
  output logic [8:0] lines
);
  // lines change on the falling sys_clk edge, away from sampling
  always_ff @(negedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lines <= flop_prims_pkg::SYNC_RESET_VAL; // idle: active-low lines high
    end else begin
      lines <= cmd;
    end
  end
endmodule

`default_nettype wire

// file: tb/flop_prims_top_bench.sv
// self-checking bench for the three sampled storage primitives
// assumes one device with defaults and one with clocked styles, other inits
`timescale 1ns/1ps
`default_nettype none

module flop_prims_top_bench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [8:0] cmd = flop_prims_pkg::SYNC_RESET_VAL;
  wire logic [8:0] ln;
  wire logic cq;
  wire logic sq;
  wire logic pq;
  wire logic cq_clk;
  wire logic sq_clk;
  wire logic pq_clk;
  localparam logic ALT_CLEAR_INIT = ~flop_prims_pkg::CLEAR_FLOP_INIT;
  localparam logic ALT_SET_INIT = ~flop_prims_pkg::SET_FLOP_INIT;
  localparam logic ALT_PRESET_INIT = ~flop_prims_pkg::PRESET_FLOP_INIT;
  int fails = 0;
  int compares = 0;

  // fabric model stands in for the surrounding user logic
  user_fabric_model i_user_fabric_model (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .cmd(cmd),
    .lines(ln)
  );

  // device under test with default parameters
  flop_prims_top i_flop_prims_top (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pos_edge_timing_in(ln[flop_prims_pkg::IDX_POS_TIMING]),
    .neg_edge_timing_in(ln[flop_prims_pkg::IDX_NEG_TIMING]),
    .clear_data_in(ln[flop_prims_pkg::IDX_CLEAR_DATA]),
    .clear_low_in(ln[flop_prims_pkg::IDX_CLEAR_LOW]),
    .set_data_in(ln[flop_prims_pkg::IDX_SET_DATA]),
    .force_high_low_in(ln[flop_prims_pkg::IDX_FORCE_HIGH_LOW]),
    .preset_data_in(ln[flop_prims_pkg::IDX_PRESET_DATA]),
    .preset_enable_in(ln[flop_prims_pkg::IDX_PRESET_EN]),
    .sync_preset_low_in(ln[flop_prims_pkg::IDX_PRESET_LOW]),
    .async_clear_flop_q(cq),
    .async_set_flop_q(sq),
    .neg_edge_sync_preset_flop_q(pq)
  );

  // second device: clocked set and clear, non-default power-up values
  flop_prims_top #(
    .CLEAR_INIT(ALT_CLEAR_INIT),
    .SET_INIT(ALT_SET_INIT),
    .PRESET_INIT(ALT_PRESET_INIT),
    .CLEAR_STYLE(flop_prims_pkg::STYLE_CLOCKED),
    .SET_STYLE(flop_prims_pkg::STYLE_CLOCKED)
  ) i_flop_prims_top_clocked (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pos_edge_timing_in(ln[flop_prims_pkg::IDX_POS_TIMING]),
    .neg_edge_timing_in(ln[flop_prims_pkg::IDX_NEG_TIMING]),
    .clear_data_in(ln[flop_prims_pkg::IDX_CLEAR_DATA]),
    .clear_low_in(ln[flop_prims_pkg::IDX_CLEAR_LOW]),
    .set_data_in(ln[flop_prims_pkg::IDX_SET_DATA]),
    .force_high_low_in(ln[flop_prims_pkg::IDX_FORCE_HIGH_LOW]),
    .preset_data_in(ln[flop_prims_pkg::IDX_PRESET_DATA]),
    .preset_enable_in(ln[flop_prims_pkg::IDX_PRESET_EN]),
    .sync_preset_low_in(ln[flop_prims_pkg::IDX_PRESET_LOW]),
    .async_clear_flop_q(cq_clk),
    .async_set_flop_q(sq_clk),
    .neg_edge_sync_preset_flop_q(pq_clk)
  );

  // 40 MHz system clock
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // change one line, then allow the synchroniser and output stage to settle
  task automatic put(input int idx, input logic v);
    @(posedge sys_clk);
    #1;
    cmd[idx] = v;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  // compare one output against its expected level
  task automatic check(input string name, input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // print the counts and the verdict, then stop
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // cut a hang short well past the expected run length
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check("clear q", cq, flop_prims_pkg::CLEAR_FLOP_INIT);
    check("set q", sq, flop_prims_pkg::SET_FLOP_INIT);
    check("preset q", pq, flop_prims_pkg::PRESET_FLOP_INIT);
    check("clocked clear q", cq_clk, ALT_CLEAR_INIT);
    check("clocked set q", sq_clk, ALT_SET_INIT);
    check("clocked preset q", pq_clk, ALT_PRESET_INIT);
    $display("test power_up done");
    // capture on rise, hold without an edge, no capture on fall
    put(flop_prims_pkg::IDX_CLEAR_DATA, 1'b1);
    put(flop_prims_pkg::IDX_POS_TIMING, 1'b1);
    check("clear q", cq, 1'b1);
    check("set q", sq, 1'b0);
    check("clocked clear q", cq_clk, 1'b1);
    check("clocked set q", sq_clk, 1'b0);
    put(flop_prims_pkg::IDX_CLEAR_DATA, 1'b0);
    check("clear q", cq, 1'b1);
    put(flop_prims_pkg::IDX_POS_TIMING, 1'b0);
    check("clear q", cq, 1'b1);
    check("clocked clear q", cq_clk, 1'b1);
    // unclocked clear acts without an edge, clocked waits; both win over a capturing edge
    put(flop_prims_pkg::IDX_CLEAR_LOW, 1'b0);
    check("clear q", cq, 1'b0);
    check("clocked clear q", cq_clk, 1'b1);
    put(flop_prims_pkg::IDX_CLEAR_DATA, 1'b1);
    put(flop_prims_pkg::IDX_POS_TIMING, 1'b1);
    check("clear q", cq, 1'b0);
    check("clocked clear q", cq_clk, 1'b0);
    put(flop_prims_pkg::IDX_CLEAR_LOW, 1'b1);
    check("clear q", cq, 1'b0);
    check("clocked clear q", cq_clk, 1'b0);
    $display("test clear_flop done");
    // set: unclocked acts at once, clocked waits for a rising edge
    put(flop_prims_pkg::IDX_FORCE_HIGH_LOW, 1'b0);
    check("set q", sq, 1'b1);
    check("clocked set q", sq_clk, 1'b0);
    put(flop_prims_pkg::IDX_POS_TIMING, 1'b0);
    put(flop_prims_pkg::IDX_POS_TIMING, 1'b1);
    check("set q", sq, 1'b1);
    check("clocked set q", sq_clk, 1'b1);
    check("clear q", cq, 1'b1);
    put(flop_prims_pkg::IDX_FORCE_HIGH_LOW, 1'b1);
    check("set q", sq, 1'b1);
    check("clocked set q", sq_clk, 1'b1);
    put(flop_prims_pkg::IDX_POS_TIMING, 1'b0);
    put(flop_prims_pkg::IDX_POS_TIMING, 1'b1);
    check("set q", sq, 1'b0);
    check("clocked set q", sq_clk, 1'b0);
    check("clear q", cq, 1'b1);
    check("clocked clear q", cq_clk, 1'b1);
    // a one on the set flop data loads only on the next rising edge
    put(flop_prims_pkg::IDX_SET_DATA, 1'b1);
    check("set q", sq, 1'b0);
    put(flop_prims_pkg::IDX_POS_TIMING, 1'b0);
    put(flop_prims_pkg::IDX_POS_TIMING, 1'b1);
    check("set q", sq, 1'b1);
    check("clocked set q", sq_clk, 1'b1);
    $display("test set_flop done");
    // preset flop: load on fall, preset on fall only, hold when disabled
    put(flop_prims_pkg::IDX_PRESET_EN, 1'b1);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b1);
    check("preset q", pq, 1'b1);
    check("clocked preset q", pq_clk, ALT_PRESET_INIT);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b0);
    check("preset q", pq, 1'b0);
    check("clocked preset q", pq_clk, 1'b0);
    put(flop_prims_pkg::IDX_PRESET_LOW, 1'b0);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b1);
    check("preset q", pq, 1'b0);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b0);
    check("preset q", pq, 1'b1);
    check("clocked preset q", pq_clk, 1'b1);
    put(flop_prims_pkg::IDX_PRESET_LOW, 1'b1);
    put(flop_prims_pkg::IDX_PRESET_EN, 1'b0);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b1);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b0);
    check("preset q", pq, 1'b1);
    put(flop_prims_pkg::IDX_PRESET_EN, 1'b1);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b1);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b0);
    check("preset q", pq, 1'b0);
    check("clocked preset q", pq_clk, 1'b0);
    // disabled flop ignores preset, data and a falling edge
    put(flop_prims_pkg::IDX_PRESET_EN, 1'b0);
    put(flop_prims_pkg::IDX_PRESET_LOW, 1'b0);
    put(flop_prims_pkg::IDX_PRESET_DATA, 1'b1);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b1);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b0);
    check("preset q", pq, 1'b0);
    check("clocked preset q", pq_clk, 1'b0);
    // enabled again with preset released, a fall loads a one from data
    put(flop_prims_pkg::IDX_PRESET_EN, 1'b1);
    put(flop_prims_pkg::IDX_PRESET_LOW, 1'b1);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b1);
    put(flop_prims_pkg::IDX_NEG_TIMING, 1'b0);
    check("preset q", pq, 1'b1);
    check("clocked preset q", pq_clk, 1'b1);
    $display("test preset_flop done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
